// file: dv/adsq_link_checker.sv
// Assertions on the core/host link and the core status outputs.
// Assumes one clock, active-low asynchronous reset, link signals as inputs.
`timescale 1ns/10ps
`include "adsq_cfg.svh"
module adsq_link_checker import adsq_pkg::*; (
  input logic ref_clk,
  input logic rstn,
  input logic regWr,
  input logic regRd,
  input logic [15:0] regAddr,
  input logic [47:0] regWrData,
  input logic regRdValid,
  input logic frameStart,
  input logic [23:0] outSample,
  input logic outValid,
  input logic coreBusy,
  input logic [11:0] pcValue
);
  logic runOn_q, runOn_d, rateOff_q, rateOff_d, runWr, rateWr;
  logic [12:0] busyCnt_q, busyCnt_d;
  logic [15:0] rateVal;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Link write decode; the rate value is split out so $past sees a signal
  assign runWr = regWr && regAddr == `ADSQ_RUN_ADDR;
  assign rateWr = regWr && regAddr == `ADSQ_RATE_ADDR;
  assign rateVal = regWrData[15:0];
  // Shadow run bit and rate-off state, length of the busy stretch
  always_comb begin
    runOn_d = runWr ? regWrData[0] : runOn_q;
    rateOff_d = rateWr ? (rateVal == `ADSQ_RATE_OFF) : rateOff_q;
    busyCnt_d = coreBusy ? busyCnt_q + 13'h0001 : 13'h0000;
  end
  // Reset matches the core: halted, pulse suppressed
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      runOn_q <= 1'b0;
      rateOff_q <= 1'b1;
      busyCnt_q <= 13'h0000;
    end else begin
      runOn_q <= runOn_d;
      rateOff_q <= rateOff_d;
      busyCnt_q <= busyCnt_d;
    end
  end
  a_read_answer: assert property (regRd |=> regRdValid)
    else $error("link read not answered next cycle");
  a_answer_cause: assert property (regRdValid |-> $past(regRd))
    else $error("read valid without a read");
  a_halt_mutes: assert property (
    runWr && !regWrData[0] |=> (outSample == 24'h000000) [*4])
    else $error("outputs not zero after halt");
  a_halt_order: assert property (
    runWr && !regWrData[0] |-> $past(rateWr) &&
    $past(rateVal) == `ADSQ_RATE_OFF)
    else $error("halt not preceded by rate off");
  a_start_order: assert property (
    runWr && regWrData[0] |-> $past(rateWr) &&
    $past(rateVal) != `ADSQ_RATE_OFF)
    else $error("start not preceded by valid rate");
  a_frame_needs_run: assert property (
    $rose(coreBusy) |-> $past(frameStart) && $past(runOn_q) &&
    !$past(rateOff_q))
    else $error("execution began without pulse and run");
  a_start_address: assert property (
    $rose(coreBusy) |-> pcValue == `ADSQ_PC_START)
    else $error("frame did not start at start address");
  a_idle_pc: assert property (!coreBusy |-> pcValue == `ADSQ_PC_START)
    else $error("idle counter away from start address");
  a_pc_steps: assert property (
    coreBusy && $past(coreBusy) && !$past(frameStart) |->
    pcValue == $past(pcValue) + 12'h001)
    else $error("program counter did not step by one");
  a_frame_limit: assert property (busyCnt_q <= 13'h0E00)
    else $error("more instructions than a frame allows");
  a_out_cause: assert property (outValid |-> $past(coreBusy))
    else $error("output update while not executing");
  c_frame: cover property ($rose(coreBusy));
  c_clip: cover property (outValid && outSample == 24'h7FFFFF);
  c_halt: cover property (runWr && !regWrData[0]);
  c_read: cover property (regRdValid);
endmodule : adsq_link_checker

// file: dv/audio_dsp_core_sequencer_bench.sv
// Bench: host and core joined by the link, driven by an APB master.
// Assumes the host paces frames itself and answers APB one cycle on.
`timescale 1ns/10ps
`include "adsq_cfg.svh"
module audio_dsp_core_sequencer_bench;
  logic ref_clk, rstn, psel, penable, pwrite, pready, pslverr, coreBusy;
  logic rerr;
  logic [11:0] paddr, pcValue;
  logic [31:0] pwdata, prdata, rdat;
  int fail_count, compares, len, hits;
  localparam logic [47:0] MUL_I = 48'h0220_0000_0000;
  localparam logic [47:0] OUT_I = 48'h0300_0000_0000;
  localparam logic [47:0] JMP_I = 48'h0700_0000_0000;
  localparam logic [23:0] IN_T [5] = '{24'h600000, 24'hA00000,
    24'hC00000, 24'h200000, 24'h123456};
  localparam logic [27:0] CF_T [5] = '{28'h1000000, 28'h1000000,
    28'h1000000, 28'h1000000, 28'h0800000};
  localparam logic [23:0] EX_T [5] = '{24'h7FFFFF, 24'h800000,
    24'h800000, 24'h400000, 24'h123456};
  localparam logic [15:0] RT_T [3] = '{16'h0000, 16'h0001, 16'h0002};
  localparam logic [11:0] LM_T [3] = '{`ADSQ_LIM_NORMAL, `ADSQ_LIM_DUAL,
    `ADSQ_LIM_QUAD};
  adsq_link_if link (.ref_clk(ref_clk));
  adsq_core i_adsq_core (.ref_clk(ref_clk), .rstn(rstn),
    .link(link.core), .coreBusy(coreBusy), .pcValue(pcValue));
  adsq_host i_adsq_host (.ref_clk(ref_clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link(link.host));
  adsq_link_checker i_adsq_link_checker (.ref_clk(ref_clk), .rstn(rstn),
    .regWr(link.regWr), .regRd(link.regRd), .regAddr(link.regAddr),
    .regWrData(link.regWrData), .regRdValid(link.regRdValid),
    .frameStart(link.frameStart), .outSample(link.outSample),
    .outValid(link.outValid), .coreBusy(coreBusy), .pcValue(pcValue));
  // 10 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic end_sim();
    if (fail_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim
  task automatic bail();
    fail_count++;
    end_sim();
  endtask : bail
  task automatic chk(input string nm, input logic [47:0] e,
    input logic [47:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) bail();
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Poll the host until its link transfer is done
  task automatic idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, `ADSQ_H_STAT, 32'h0);
      n++;
    end while (rdat[0] !== 1'b0 && n < 20);
    if (n >= 20) bail();
  endtask : idle
  task automatic cwr(input logic [15:0] a, input logic [47:0] d);
    apb(1'b1, `ADSQ_H_ADDR, {16'h0, a});
    apb(1'b1, `ADSQ_H_DLO, d[31:0]);
    apb(1'b1, `ADSQ_H_DHI, {16'h0, d[47:32]});
    apb(1'b1, `ADSQ_H_XFER, 32'h0);
    idle();
  endtask : cwr
  task automatic crd(input logic [15:0] a);
    apb(1'b1, `ADSQ_H_ADDR, {16'h0, a});
    apb(1'b1, `ADSQ_H_XFER, 32'h1);
    idle();
    apb(1'b0, `ADSQ_H_RDAT, 32'h0);
  endtask : crd
  task automatic wait_out();
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (link.outValid !== 1'b1 && n < 9000);
    if (n >= 9000) bail();
  endtask : wait_out
  // Length of the next busy stretch, in cycles
  task automatic blen();
    int n;
    n = 0;
    while (coreBusy !== 1'b1 && n < 9000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 9000) bail();
    len = 0;
    while (coreBusy === 1'b1 && len < 5000) begin
      @(posedge ref_clk);
      len++;
    end
  endtask : blen
  task automatic nobusy(input int cyc);
    hits = 0;
    repeat (cyc) begin
      @(posedge ref_clk);
      if (coreBusy !== 1'b0) hits++;
    end
  endtask : nobusy
  // Main sequence
  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    fail_count = 0;
    compares = 0;
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    chk("pc", 12'h010, pcValue);
    apb(1'b0, 12'h028, 32'h0);
    chk("pslverr", 1'b1, rerr);
    crd(`ADSQ_RUN_ADDR);
    chk("run reset", 16'h0000, rdat);
    crd(`ADSQ_RATE_ADDR);
    chk("rate reset", 16'h001C, rdat);
    apb(1'b1, `ADSQ_H_RATE, 32'h0);
    apb(1'b1, `ADSQ_H_CMD, 32'h1);
    nobusy(7700);
    chk("busy empty", 32'h0, hits);
    crd(`ADSQ_RUN_ADDR);
    chk("run set", 16'h0001, rdat);
    cwr(16'h2010, MUL_I);
    cwr(16'h2011, OUT_I);
    cwr(16'h2012, JMP_I);
    blen();
    chk("jump len", 32'h3, len);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, `ADSQ_H_INS, {8'h00, IN_T[i]});
      cwr(16'h0000, {20'h0, CF_T[i]});
      wait_out();
      wait_out();
      chk("out", EX_T[i], link.outSample);
      apb(1'b0, `ADSQ_H_OUTS, 32'h0);
      chk("outs", EX_T[i], rdat[23:0]);
    end
    cwr(16'h2012, 48'h0);
    for (int r = 0; r < 3; r++) begin
      apb(1'b1, `ADSQ_H_RATE, {16'h0, RT_T[r]});
      apb(1'b1, `ADSQ_H_CMD, 32'h1);
      blen();
      blen();
      chk("limit", LM_T[r], len);
    end
    crd(`ADSQ_PEAK_ADDR);
    chk("peak", LM_T[2], rdat);
    // second accumulator, ROM operands and MAC; blen lets a frame
    // that began during the load finish before the output is taken
    cwr(16'h2013, JMP_I);
    cwr(16'h2012, 48'h0340_0000_0000);
    cwr(16'h2011, 48'h0158_0000_0002);
    cwr(16'h2010, 48'h0268_0000_0001);
    blen();
    wait_out();
    chk("mac out", 24'h323456, link.outSample);
    crd(`ADSQ_PEAK_ADDR);
    chk("peak jump", 32'h4, rdat);
    apb(1'b1, `ADSQ_H_CMD, 32'h2);
    repeat (6) @(posedge ref_clk);
    chk("halt out", 24'h0, link.outSample);
    crd(`ADSQ_RUN_ADDR);
    chk("run clr", 16'h0000, rdat);
    crd(`ADSQ_RATE_ADDR);
    chk("rate off", 16'h001C, rdat);
    nobusy(4000);
    chk("busy halted", 32'h0, hits);
    chk("pc idle", 12'h010, pcValue);
    end_sim();
  end
endmodule : audio_dsp_core_sequencer_bench

// file: verilog/adsq_cfg.svh
// Offsets, field positions, reset values and counts for the sequencer core.
// Assumes nothing; included by the design modules, the checker and the bench.
`ifndef ADSQ_CFG_SVH
`define ADSQ_CFG_SVH
// Device register map on the link register port (16-bit word addresses)
`define ADSQ_PARAM_BASE 16'h0000
`define ADSQ_PROG_BASE 16'h2000
`define ADSQ_DATA_BASE 16'h4000
`define ADSQ_RATE_ADDR 16'hE220
`define ADSQ_RUN_ADDR 16'hE228
`define ADSQ_PEAK_ADDR 16'hE229
`define ADSQ_RUN_RESET 16'h0000
`define ADSQ_RATE_RESET 16'h001C
`define ADSQ_RATE_OFF 16'h001C
`define ADSQ_RATE_DUAL 16'h0001
`define ADSQ_RATE_QUAD 16'h0002
// Program memory
`define ADSQ_PC_START 12'h010
`define ADSQ_LIM_NORMAL 12'hE00
`define ADSQ_LIM_DUAL 12'h700
`define ADSQ_LIM_QUAD 12'h380
// Instruction fields
`define ADSQ_OP_HI 42
`define ADSQ_OP_LO 40
`define ADSQ_ACC_HI 39
`define ADSQ_ACC_LO 38
`define ADSQ_DSRC_HI 37
`define ADSQ_DSRC_LO 36
`define ADSQ_CSRC_BIT 35
`define ADSQ_DADDR_HI 34
`define ADSQ_DADDR_LO 22
`define ADSQ_PADDR_HI 21
`define ADSQ_PADDR_LO 10
`define ADSQ_ROM_HI 3
`define ADSQ_ROM_LO 0
// Host-side APB register offsets
`define ADSQ_H_CMD 12'h000
`define ADSQ_H_RATE 12'h004
`define ADSQ_H_ADDR 12'h008
`define ADSQ_H_DLO 12'h00C
`define ADSQ_H_DHI 12'h010
`define ADSQ_H_XFER 12'h014
`define ADSQ_H_INS 12'h018
`define ADSQ_H_OUTS 12'h01C
`define ADSQ_H_STAT 12'h020
`define ADSQ_H_RDAT 12'h024
// Frame pacing on the host end, in ref_clk cycles
`define ADSQ_FRAME_CYCLES 16'h0F00
`endif

// file: verilog/adsq_core.sv
// Audio sequencer core: MAC datapath, program counter, run control.
// Assumes the host end feeds register writes and one frame pulse per
// audio frame on the same clock.
// Notes on behaviour
// - 28-bit multiply into 56-bit accumulators, three.
// - Data and coefficient operand source selection.
// - Accumulator out as 28-bit or RAM write-back.
// - Operands are 5.23 two's-complement fractions.
// - 24-bit inputs sign-extended to 28 bits.
// - Outputs saturated to 24-bit, plus/minus one.
// - 3584 instructions per frame at normal rate.
// - Dual and quad rate cut instruction count.
// - No program runs before host loads one.
// - Program counter steps, restarts each frame.
// - Jump-to-start loads start address, then waits.
// - Programs must return before next frame.
// - Run bit zero at reset, starts core.
// - Host writes rate off before halting.
// - Host writes valid rate before starting.
// - Clearing run zeroes serial outputs immediately.
// - 43-bit opcodes, 4096 words at program base.
// - Dual limit 1792, quad limit 896.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`include "adsq_cfg.svh"
module adsq_core import adsq_pkg::*; (
  input wire logic ref_clk,
  input wire logic rstn,
  adsq_link_if.core link,
  output logic coreBusy,
  output logic [11:0] pcValue
);
  logic [42:0] progRam [4096];
  logic signed [27:0] paramRam [4096];
  logic signed [27:0] dataRam [8192];

  function automatic logic signed [27:0] romConst(input logic [3:0] idx);
    unique case (idx)
      4'h0: romConst = 28'h0000000;
      4'h1: romConst = 28'h0800000;
      4'h2: romConst = 28'h0400000;
      4'h3: romConst = 28'hF800000;
      4'h4: romConst = 28'h1000000;
      4'h5: romConst = 28'h0200000;
      default: romConst = 28'h0000000;
    endcase
  endfunction : romConst

  // clip top four bits to 24-bit range
  function automatic logic [23:0] clip24(input logic [27:0] v);
    if (v[27:23] == 5'h00 || v[27:23] == 5'h1F)
      clip24 = v[23:0];
    else if (v[27])
      clip24 = 24'h800000;
    else
      clip24 = 24'h7FFFFF;
  endfunction : clip24

  // Narrow an accumulator back to 5.23
  function automatic logic [27:0] acc28(input logic [55:0] a);
    acc28 = a[50:23];
  endfunction : acc28

  adsq_seq_type state_q, state_d;
  logic [11:0] pc_q, pc_d;
  logic [11:0] cnt_q, cnt_d;
  logic [11:0] peak_q, peak_d;
  logic [15:0] run_q, run_d;
  logic [15:0] rate_q, rate_d;
  logic loaded_q, loaded_d;
  logic [27:0] inLatch_q, inLatch_d;
  logic [23:0] outSample_q, outSample_d;
  logic outValid_q, outValid_d;
  logic [47:0] rdData_q, rdData_d;
  logic rdValid_q, rdValid_d;
  logic signed [55:0] acc_q [3];
  logic signed [55:0] acc_d [3];

  logic [42:0] instr;
  adsq_op_type op;
  logic [1:0] accSel;
  logic signed [27:0] dataOp, coefOp;
  logic signed [55:0] product;
  logic [11:0] limit;
  logic startOk;
  logic coreWr, coreWrParam;
  logic [27:0] coreWrData;

  always_comb begin
    instr = progRam[pc_q];
    op = adsq_op_type'(instr[`ADSQ_OP_HI:`ADSQ_OP_LO]);
    accSel = instr[`ADSQ_ACC_HI:`ADSQ_ACC_LO];
    if (accSel == 2'h3)
      accSel = 2'h2; // Only three accumulators exist
    unique case (instr[`ADSQ_DSRC_HI:`ADSQ_DSRC_LO])
      DSRC_DRAM: dataOp = dataRam[instr[`ADSQ_DADDR_HI:`ADSQ_DADDR_LO]];
      DSRC_ROM: dataOp = romConst(instr[`ADSQ_ROM_HI:`ADSQ_ROM_LO]);
      default: dataOp = inLatch_q;
    endcase
    if (instr[`ADSQ_CSRC_BIT])
      coefOp = romConst(instr[`ADSQ_ROM_HI:`ADSQ_ROM_LO]);
    else
      coefOp = paramRam[instr[`ADSQ_PADDR_HI:`ADSQ_PADDR_LO]];
    product = dataOp * coefOp;
  end

  always_comb begin
    unique case (rate_q)
      `ADSQ_RATE_DUAL: limit = `ADSQ_LIM_DUAL;
      `ADSQ_RATE_QUAD: limit = `ADSQ_LIM_QUAD;
      default: limit = `ADSQ_LIM_NORMAL;
    endcase
    // start needs run, a rate and a loaded program
    startOk = link.frameStart && run_q[0] && loaded_q &&
      rate_q != `ADSQ_RATE_OFF;
  end

  // Sequencer and datapath next state
  always_comb begin
    state_d = state_q;
    pc_d = pc_q;
    cnt_d = cnt_q;
    peak_d = peak_q;
    inLatch_d = inLatch_q;
    outSample_d = outSample_q;
    outValid_d = 1'b0;
    acc_d = acc_q;
    coreWr = 1'b0;
    coreWrParam = 1'b0;
    coreWrData = acc28(acc_q[accSel]);
    unique case (state_q)
      SEQ_IDLE, SEQ_WAIT: begin
        // hold at start address until a frame
        pc_d = `ADSQ_PC_START;
        if (startOk) begin
          state_d = SEQ_EXEC;
          cnt_d = 12'h000;
          inLatch_d = {{4{link.inSample[23]}}, link.inSample};
        end
      end
      SEQ_EXEC: begin
        pc_d = pc_q + 12'h001;
        cnt_d = cnt_q + 12'h001;
        unique case (op)
          OP_MAC: acc_d[accSel] = acc_q[accSel] + product;
          OP_MUL: acc_d[accSel] = product;
          // output in 28-bit form through the clipper
          OP_OUT: begin
            outSample_d = clip24(acc28(acc_q[accSel]));
            outValid_d = 1'b1;
          end
          // write-back to data or parameter memory
          OP_WDATA: coreWr = 1'b1;
          OP_WPARAM: coreWrParam = 1'b1;
          default: ;
        endcase
        if (op == OP_JUMP || cnt_d == limit) begin
          state_d = SEQ_WAIT;
          pc_d = `ADSQ_PC_START;
          peak_d = cnt_d;
        end else if (startOk) begin
          // overrun: restart, audio is not trustworthy
          state_d = SEQ_EXEC;
          pc_d = `ADSQ_PC_START;
          cnt_d = 12'h000;
          inLatch_d = {{4{link.inSample[23]}}, link.inSample};
        end
      end
      default: state_d = SEQ_IDLE;
    endcase
    // halt mutes outputs at once; the next run value is used so
    // the edge that takes the clearing write already zeroes the sample
    if (!run_d[0]) begin
      state_d = SEQ_IDLE;
      pc_d = `ADSQ_PC_START;
      outSample_d = 24'h000000;
    end
  end

  // Register port: run, rate, loaded flag, readback
  always_comb begin
    run_d = run_q;
    rate_d = rate_q;
    loaded_d = loaded_q;
    rdValid_d = link.regRd;
    rdData_d = 48'h000000000000;
    if (link.regWr) begin
      if (link.regAddr == `ADSQ_RUN_ADDR)
        run_d = {15'h0000, link.regWrData[0]};
      if (link.regAddr == `ADSQ_RATE_ADDR)
        rate_d = link.regWrData[15:0];
      if (link.regAddr[15:12] == 4'(`ADSQ_PROG_BASE >> 12))
        loaded_d = 1'b1;
    end
    if (link.regRd) begin
      unique case (link.regAddr)
        `ADSQ_RUN_ADDR: rdData_d = {32'h00000000, run_q};
        `ADSQ_RATE_ADDR: rdData_d = {32'h00000000, rate_q};
        `ADSQ_PEAK_ADDR: rdData_d = {36'h000000000, peak_q};
        default: rdData_d = 48'h000000000000;
      endcase
    end
  end

  // Control state registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= SEQ_IDLE;
      pc_q <= `ADSQ_PC_START;
      cnt_q <= 12'h000;
      peak_q <= 12'h000;
      run_q <= `ADSQ_RUN_RESET;
      rate_q <= `ADSQ_RATE_RESET;
      loaded_q <= 1'b0;
      inLatch_q <= 28'h0000000;
      outSample_q <= 24'h000000;
      outValid_q <= 1'b0;
      rdData_q <= 48'h000000000000;
      rdValid_q <= 1'b0;
      coreBusy <= 1'b0;
      pcValue <= `ADSQ_PC_START;
      for (int i = 0; i < 3; i++)
        acc_q[i] <= 56'h00000000000000;
    end else begin
      state_q <= state_d;
      pc_q <= pc_d;
      cnt_q <= cnt_d;
      peak_q <= peak_d;
      run_q <= run_d;
      rate_q <= rate_d;
      loaded_q <= loaded_d;
      inLatch_q <= inLatch_d;
      outSample_q <= outSample_d;
      outValid_q <= outValid_d;
      rdData_q <= rdData_d;
      rdValid_q <= rdValid_d;
      coreBusy <= (state_d == SEQ_EXEC);
      pcValue <= pc_d;
      acc_q <= acc_d;
    end
  end

  // Memories: host loads win over core write-back in the same cycle
  always_ff @(posedge ref_clk) begin
    if (link.regWr && link.regAddr[15:12] == 4'(`ADSQ_PROG_BASE >> 12))
      progRam[link.regAddr[11:0]] <= link.regWrData[42:0];
    if (link.regWr && link.regAddr[15:12] == 4'(`ADSQ_PARAM_BASE >> 12))
      paramRam[link.regAddr[11:0]] <= link.regWrData[27:0];
    else if (coreWrParam)
      paramRam[instr[`ADSQ_PADDR_HI:`ADSQ_PADDR_LO]] <= coreWrData;
    if (link.regWr && link.regAddr[15:13] == 3'(`ADSQ_DATA_BASE >> 13))
      dataRam[link.regAddr[12:0]] <= link.regWrData[27:0];
    else if (coreWr)
      dataRam[instr[`ADSQ_DADDR_HI:`ADSQ_DADDR_LO]] <= coreWrData;
  end

  assign link.outSample = outSample_q;
  assign link.outValid = outValid_q;
  assign link.regRdData = rdData_q;
  assign link.regRdValid = rdValid_q;
endmodule : adsq_core

// file: verilog/adsq_host.sv
// Host end: APB register slave, frame pacing and ordered run/halt writes.
// Assumes an APB master on ref_clk and the core on the same clock.
`timescale 1ns/10ps
`include "adsq_cfg.svh"
module adsq_host import adsq_pkg::*; (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  adsq_link_if.host link
);
  adsq_host_type st_q, st_d;
  logic [15:0] rate_q, rate_d, addr_q, addr_d;
  logic [47:0] data_q, data_d, rdat_q, rdat_d;
  logic [23:0] ins_q, ins_d, outs_q, outs_d;
  logic [15:0] frm_q, frm_d;
  logic wr_q, wr_d, rd_q, rd_d, fs_q, fs_d, halt_q, halt_d;
  logic [15:0] wa_q, wa_d;
  logic [47:0] wd_q, wd_d;
  logic [31:0] prdata_d;
  logic pready_d, pslverr_d, acc, mapped;

  // APB decode; access phase is always one cycle long
  always_comb begin
    acc = psel && penable && pready;
    mapped = paddr <= `ADSQ_H_RDAT && paddr[1:0] == 2'b00;
    pready_d = psel && !penable;
    pslverr_d = psel && !penable && !mapped;
    unique case (paddr)
      `ADSQ_H_RATE: prdata_d = {16'h0000, rate_q};
      `ADSQ_H_ADDR: prdata_d = {16'h0000, addr_q};
      `ADSQ_H_DLO: prdata_d = data_q[31:0];
      `ADSQ_H_DHI: prdata_d = {16'h0000, data_q[47:32]};
      `ADSQ_H_INS: prdata_d = {8'h00, ins_q};
      `ADSQ_H_OUTS: prdata_d = {8'h00, outs_q};
      `ADSQ_H_STAT: prdata_d = {31'h00000000, st_q != HST_IDLE};
      `ADSQ_H_RDAT: prdata_d = rdat_q[31:0];
      default: prdata_d = 32'h00000000;
    endcase
  end

  // Register writes, command sequencing and frame pacing
  always_comb begin
    st_d = st_q;
    rate_d = rate_q;
    addr_d = addr_q;
    data_d = data_q;
    ins_d = ins_q;
    halt_d = halt_q;
    rdat_d = link.regRdValid ? link.regRdData : rdat_q;
    outs_d = link.outValid ? link.outSample : outs_q;
    wr_d = 1'b0;
    rd_d = 1'b0;
    wa_d = wa_q;
    wd_d = wd_q;
    frm_d = frm_q + 16'h0001;
    fs_d = 1'b0;
    if (frm_q == `ADSQ_FRAME_CYCLES - 16'h0001) begin
      frm_d = 16'h0000;
      fs_d = 1'b1;
    end
    if (acc && pwrite) begin
      unique case (paddr)
        `ADSQ_H_RATE: rate_d = pwdata[15:0];
        `ADSQ_H_ADDR: addr_d = pwdata[15:0];
        `ADSQ_H_DLO: data_d[31:0] = pwdata;
        `ADSQ_H_DHI: data_d[47:32] = pwdata[15:0];
        `ADSQ_H_INS: ins_d = pwdata[23:0];
        default: ;
      endcase
    end
    unique case (st_q)
      HST_IDLE: begin
        if (acc && pwrite && paddr == `ADSQ_H_CMD && pwdata[1:0] != 2'b00)
        begin
          // halt: rate off first; start: rate first
          st_d = HST_RATE;
          halt_d = pwdata[1];
          wr_d = 1'b1;
          wa_d = `ADSQ_RATE_ADDR;
          wd_d = {32'h00000000, pwdata[1] ? `ADSQ_RATE_OFF : rate_q};
        end else if (acc && pwrite && paddr == `ADSQ_H_XFER) begin
          st_d = pwdata[0] ? HST_READ : HST_RAW;
          wr_d = !pwdata[0];
          rd_d = pwdata[0];
          wa_d = addr_q;
          wd_d = data_q;
        end
      end
      HST_RATE: begin
        st_d = HST_RUN;
        wr_d = 1'b1;
        wa_d = `ADSQ_RUN_ADDR;
        wd_d = {47'h000000000000, !halt_q};
      end
      HST_READ: if (link.regRdValid) st_d = HST_IDLE;
      default: st_d = HST_IDLE;
    endcase
  end

  // State registers; every port output is a flop
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= HST_IDLE;
      rate_q <= 16'h0000;
      addr_q <= 16'h0000;
      data_q <= 48'h000000000000;
      rdat_q <= 48'h000000000000;
      ins_q <= 24'h000000;
      outs_q <= 24'h000000;
      frm_q <= 16'h0000;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      fs_q <= 1'b0;
      halt_q <= 1'b0;
      wa_q <= 16'h0000;
      wd_q <= 48'h000000000000;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      st_q <= st_d;
      rate_q <= rate_d;
      addr_q <= addr_d;
      data_q <= data_d;
      rdat_q <= rdat_d;
      ins_q <= ins_d;
      outs_q <= outs_d;
      frm_q <= frm_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      fs_q <= fs_d;
      halt_q <= halt_d;
      wa_q <= wa_d;
      wd_q <= wd_d;
      prdata <= prdata_d;
      pready <= pready_d;
      pslverr <= pslverr_d;
    end
  end

  assign link.regWr = wr_q;
  assign link.regRd = rd_q;
  assign link.regAddr = wa_q;
  assign link.regWrData = wd_q;
  assign link.frameStart = fs_q;
  assign link.inSample = ins_q;
endmodule : adsq_host

// file: verilog/adsq_link_if.sv
// Link between the sequencer core and its host / frame source.
// Assumes one clock shared by both ends.
`timescale 1ns/10ps
interface adsq_link_if (input logic ref_clk);
  logic regWr;
  logic regRd;
  logic [15:0] regAddr;
  logic [47:0] regWrData;
  logic [47:0] regRdData;
  logic regRdValid;
  logic frameStart;
  logic [23:0] inSample;
  logic [23:0] outSample;
  logic outValid;
  modport core (input regWr, regRd, regAddr, regWrData, frameStart,
    inSample, output regRdData, regRdValid, outSample, outValid);
  modport host (output regWr, regRd, regAddr, regWrData, frameStart,
    inSample, input regRdData, regRdValid, outSample, outValid);
endinterface : adsq_link_if

// file: verilog/adsq_pkg.sv
// Types shared by both ends of the sequencer link.
// Assumes nothing; numeric constants are in adsq_cfg.svh.
package adsq_pkg;
  typedef enum logic [2:0] {
    OP_NOP = 3'h0, OP_MAC = 3'h1, OP_MUL = 3'h2, OP_OUT = 3'h3,
    OP_WDATA = 3'h4, OP_WPARAM = 3'h5, OP_JUMP = 3'h7
  } adsq_op_type;
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00, SEQ_EXEC = 2'b01, SEQ_WAIT = 2'b11
  } adsq_seq_type;
  typedef enum logic [1:0] {
    DSRC_DRAM = 2'h0, DSRC_ROM = 2'h1, DSRC_AUDIO = 2'h2
  } adsq_dsrc_type;
  typedef enum logic [2:0] {
    HST_IDLE = 3'b000, HST_RATE = 3'b001, HST_RUN = 3'b011,
    HST_RAW = 3'b010, HST_READ = 3'b110
  } adsq_host_type;
endpackage : adsq_pkg
